// file: logic/tbso_regs.vh
// Register map, field positions, codes and reset values of the trace buffer sync block.
// Overview of operation
// - Leaving halted debug acts as a context sync event for later register effects and trace.
// - A data barrier after a sync event, trace prohibition and a trace barrier waits for all buffer writes.
// - That wait also covers speculative trace not ordered after the sync event.
// - Speculative trace after a resolved post-sync instruction sees register writes made before the sync.
// - Trace is prohibited at every exception level above the owning level.
// - Unsynchronised, trace may see the old or new value of a rewritten register, per read.
// - Unsynchronised, a software read of a trace-updated register may show old or new value.
// - Trace found late to be disabled is written, sent on the side bus, both, or discarded.
// - The same late-disable choice applies to data flushed out of the trace unit.
// - A discard may raise a management event with error class 0x00 or 0x1F.
// - With error class 0x00 the buffer status code is written 0b000000, buffer not full.
// - Discarded or not, the write pointer may advance, the trigger count drop and events fire.
// - The owner control is sampled at generation for permission and at completion for pointer context.
// - A trace barrier in debug state takes debug entry in place of the sync event.
// - Running in debug state with the trace unit disabled counts as a trace-prohibited region.
`ifndef TBSO_REGS_VH
`define TBSO_REGS_VH
`define TBSO_OFS_CTRL 8'h00
`define TBSO_OFS_STATUS 8'h04
`define TBSO_OFS_PTR_EL1 8'h08
`define TBSO_OFS_PTR_EL2 8'h0C
`define TBSO_OFS_TRIGCNT 8'h10
`define TBSO_OFS_IRQSTAT 8'h14
`define TBSO_OFS_IRQMASK 8'h18
// Control register fields.
`define TBSO_CTRL_EN 0
`define TBSO_CTRL_POL_LO 1
`define TBSO_CTRL_POL_HI 2
`define TBSO_CTRL_EVTEN 3
`define TBSO_CTRL_ECIMP 4
`define TBSO_CTRL_ADV 5
`define TBSO_CTRL_HYPOWN 6
`define TBSO_CTRL_W 7
// Late-disable policy codes.
`define TBSO_POL_MEM 2'h0
`define TBSO_POL_SIDE 2'h1
`define TBSO_POL_BOTH 2'h2
`define TBSO_POL_DISCARD 2'h3
// Status register fields.
`define TBSO_ST_EC_LO 26
`define TBSO_ST_TRG 22
`define TBSO_ST_MGMT 16
`define TBSO_EC_OTHER 6'h00
`define TBSO_EC_IMPDEF 6'h1F
`define TBSO_BSC_NOT_FULL 6'h00
// Interrupt status bits.
`define TBSO_IRQ_MGMT 0
`define TBSO_IRQ_TRIG 1
`define TBSO_IRQ_DISCARD 2
`define TBSO_IRQ_W 3
// Reset values and step.
`define TBSO_CTRL_RST 7'h00
`define TBSO_PTR_RST 32'h00000000
`define TBSO_PTR_STEP 32'h00000004
`define TBSO_EL1 2'h1
`define TBSO_EL2 2'h2
`endif

// file: logic/tbso_trace_buffer_sync.v
// Trace buffer unit with barrier ordering, late-disable handling and register port.
`timescale 1ns/1ps
`include "tbso_regs.vh"

module tbso_trace_buffer_sync (
	input wire clk,
	input wire resetn,
	input wire [7:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [31:0] regRdData,
	input wire contextSyncEvent,
	input wire debugEntry,
	input wire debugExit,
	input wire inDebugState,
	input wire traceUnitEnabled,
	input wire [1:0] currentEl,
	input wire traceBarrier,
	input wire dataBarrierReq,
	output reg dataBarrierDone,
	input wire traceValid,
	input wire [31:0] traceData,
	input wire traceAfterCse,
	input wire traceFlush,
	output wire traceReady,
	output wire traceProhibited,
	output wire memReq,
	output reg [31:0] memAddr,
	output reg [31:0] memData,
	input wire memAccept,
	input wire memComplete,
	output reg sideValid,
	output reg [31:0] sideData,
	output reg pmuEvent,
	output wire irq
);

////////////////////////////////////////////////////////////////////////////////
// Control views. The live copy is what software wrote; the synced copy is
// taken at each sync event, the older copy is the one before that.

reg [`TBSO_CTRL_W-1:0] ctrlLive;
reg [`TBSO_CTRL_W-1:0] ctrlSynced;
reg [`TBSO_CTRL_W-1:0] ctrlOld;
reg [5:0] errClass;
reg [5:0] bufStatus;
reg triggeredFlag;
reg mgmtFlag;
reg [31:0] ptrEl1;
reg [31:0] ptrEl2;
reg [15:0] trigCount;
reg [`TBSO_IRQ_W-1:0] irqStat;
reg [`TBSO_IRQ_W-1:0] irqMask;
reg cseSeen;
reg barrierArmed;
reg barrierWait;
reg [3:0] outstanding;
reg stValid;
reg stFlush;
reg [31:0] stData;
reg sideFromFlush;

// Any event that resynchronises context.
// debug exit syncs
wire syncNow = contextSyncEvent | debugExit;

// The owning level follows the hypervisor owner bit of a given view.
function [1:0] ownerOf;
	input [`TBSO_CTRL_W-1:0] view;
	begin
		ownerOf = view[`TBSO_CTRL_HYPOWN] ? `TBSO_EL2 : `TBSO_EL1;
	end
endfunction

wire [`TBSO_CTRL_W-1:0] genView = traceAfterCse ? ctrlSynced : ctrlOld;

assign traceProhibited = (currentEl > ownerOf(genView)) |
	(inDebugState & ~traceUnitEnabled);

wire genAllowed = genView[`TBSO_CTRL_EN] & ~traceProhibited;

////////////////////////////////////////////////////////////////////////////////
// Completion stage decisions, taken from the live view at completion time.

wire lateDisabled = ~ctrlLive[`TBSO_CTRL_EN];
wire [1:0] policy = ctrlLive[`TBSO_CTRL_POL_HI:`TBSO_CTRL_POL_LO];
wire toMem = ~lateDisabled | (policy == `TBSO_POL_MEM) | (policy == `TBSO_POL_BOTH);
wire toSide = lateDisabled & ((policy == `TBSO_POL_SIDE) | (policy == `TBSO_POL_BOTH));
wire discard = lateDisabled & (policy == `TBSO_POL_DISCARD);

assign memReq = stValid & toMem;
wire retire = stValid & (~toMem | memAccept);
// The stage frees in the cycle it retires, so a steady stream runs at one per cycle.
assign traceReady = ~stValid | retire;
wire take = traceValid & traceReady & genAllowed;

wire hypContext = ctrlLive[`TBSO_CTRL_HYPOWN];
wire written = retire & toMem;
wire advance = written | (retire & discard & ctrlLive[`TBSO_CTRL_ADV]);
wire trigHit = advance & triggeredFlag & (trigCount == 16'h0001);
wire discardEvent = retire & discard & ctrlLive[`TBSO_CTRL_EVTEN];

////////////////////////////////////////////////////////////////////////////////
// Completion stage and output registers.
always @(posedge clk) begin
	if (!resetn) begin
		stValid <= 1'b0;
		stFlush <= 1'b0;
		stData <= 32'h00000000;
		memAddr <= 32'h00000000;
		memData <= 32'h00000000;
		sideValid <= 1'b0;
		sideData <= 32'h00000000;
		sideFromFlush <= 1'b0;
		pmuEvent <= 1'b0;
	end else begin
		sideValid <= retire & toSide;
		pmuEvent <= advance;
		if (retire & toSide) begin
			sideData <= stData;
			sideFromFlush <= stFlush;
		end
		if (take) begin
			stValid <= 1'b1;
			stData <= traceData;
			stFlush <= traceFlush;
			memData <= traceData;
		end else if (retire) begin
			stValid <= 1'b0;
		end
		// The address follows the pointer of whichever owner is live now.
		memAddr <= hypContext ? ptrEl2 : ptrEl1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Outstanding writes. A completion never precedes its accept, so the count
// cannot underflow; fifteen in flight is the most the four-bit count can hold.
always @(posedge clk) begin
	if (!resetn) begin
		outstanding <= 4'h0;
	end else if (written & ~memComplete) begin
		outstanding <= outstanding + 4'h1;
	end else if (~written & memComplete & (outstanding != 4'h0)) begin
		outstanding <= outstanding - 4'h1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Barrier tracking. A trace barrier arms only after a sync event while trace
// is prohibited; a data barrier then holds until the buffer has drained.
wire drained = ~stValid & (outstanding == 4'h0) & ~(written & ~memComplete);
always @(posedge clk) begin
	if (!resetn) begin
		cseSeen <= 1'b0;
		barrierArmed <= 1'b0;
		barrierWait <= 1'b0;
		dataBarrierDone <= 1'b0;
	end else begin
		dataBarrierDone <= 1'b0;
		if (syncNow | debugEntry) begin
			cseSeen <= 1'b1;
		end else if (~traceProhibited) begin
			cseSeen <= 1'b0;
		end
		if (traceBarrier & cseSeen & traceProhibited) begin
			barrierArmed <= 1'b1;
		end
		if (dataBarrierReq) begin
			barrierWait <= 1'b1;
		end
		if (barrierWait | dataBarrierReq) begin
			if (~(barrierArmed | (traceBarrier & cseSeen & traceProhibited)) | drained) begin
				dataBarrierDone <= 1'b1;
				barrierWait <= 1'b0;
				barrierArmed <= 1'b0;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control copies and pointer, trigger and status updates.
always @(posedge clk) begin
	if (!resetn) begin
		ctrlLive <= `TBSO_CTRL_RST;
		ctrlSynced <= `TBSO_CTRL_RST;
		ctrlOld <= `TBSO_CTRL_RST;
		ptrEl1 <= `TBSO_PTR_RST;
		ptrEl2 <= `TBSO_PTR_RST;
		trigCount <= 16'h0000;
		errClass <= 6'h00;
		bufStatus <= 6'h00;
		triggeredFlag <= 1'b0;
		mgmtFlag <= 1'b0;
		irqMask <= 3'h0;
	end else begin
		if (syncNow | debugEntry) begin
			ctrlOld <= ctrlSynced;
			ctrlSynced <= ctrlLive;
		end
		if (regWr & (regAddr == `TBSO_OFS_CTRL)) begin
			ctrlLive <= regWrData[`TBSO_CTRL_W-1:0];
		end
		if (regWr & (regAddr == `TBSO_OFS_IRQMASK)) begin
			irqMask <= regWrData[`TBSO_IRQ_W-1:0];
		end
		if (advance & ~hypContext) begin
			ptrEl1 <= ptrEl1 + `TBSO_PTR_STEP;
		end else if (regWr & (regAddr == `TBSO_OFS_PTR_EL1)) begin
			ptrEl1 <= regWrData;
		end
		if (advance & hypContext) begin
			ptrEl2 <= ptrEl2 + `TBSO_PTR_STEP;
		end else if (regWr & (regAddr == `TBSO_OFS_PTR_EL2)) begin
			ptrEl2 <= regWrData;
		end
		if (advance & triggeredFlag & (trigCount != 16'h0000)) begin
			trigCount <= trigCount - 16'h0001;
		end else if (regWr & (regAddr == `TBSO_OFS_TRIGCNT)) begin
			trigCount <= regWrData[15:0];
		end
		if (discardEvent) begin
			mgmtFlag <= 1'b1;
			if (ctrlLive[`TBSO_CTRL_ECIMP]) begin
				errClass <= `TBSO_EC_IMPDEF;
			end else begin
				errClass <= `TBSO_EC_OTHER;
				bufStatus <= `TBSO_BSC_NOT_FULL;
			end
		end else if (regWr & (regAddr == `TBSO_OFS_STATUS)) begin
			errClass <= regWrData[`TBSO_ST_EC_LO+5:`TBSO_ST_EC_LO];
			bufStatus <= regWrData[5:0];
			mgmtFlag <= regWrData[`TBSO_ST_MGMT];
		end
		if (regWr & (regAddr == `TBSO_OFS_STATUS)) begin
			triggeredFlag <= regWrData[`TBSO_ST_TRG];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt status: events set, a read clears, and a set in the clearing
// cycle survives.
wire [`TBSO_IRQ_W-1:0] irqSet = {discardEvent, trigHit, discardEvent};
wire irqRead = regRd & (regAddr == `TBSO_OFS_IRQSTAT);
always @(posedge clk) begin
	if (!resetn) begin
		irqStat <= 3'h0;
	end else begin
		irqStat <= (irqRead ? 3'h0 : irqStat) | irqSet;
	end
end

assign irq = |(irqStat & irqMask);

////////////////////////////////////////////////////////////////////////////////
// Read port; unmapped addresses read zero.
always @(posedge clk) begin
	if (!resetn) begin
		regRdData <= 32'h00000000;
	end else if (regRd) begin
		if (regAddr == `TBSO_OFS_CTRL) begin
			regRdData <= {25'h0000000, ctrlLive};
		end else if (regAddr == `TBSO_OFS_STATUS) begin
			regRdData <= {errClass, 3'h0, triggeredFlag, 5'h00, mgmtFlag,
				sideFromFlush, barrierArmed, outstanding, 4'h0, bufStatus};
		end else if (regAddr == `TBSO_OFS_PTR_EL1) begin
			regRdData <= ptrEl1;
		end else if (regAddr == `TBSO_OFS_PTR_EL2) begin
			regRdData <= ptrEl2;
		end else if (regAddr == `TBSO_OFS_TRIGCNT) begin
			regRdData <= {16'h0000, trigCount};
		end else if (regAddr == `TBSO_OFS_IRQSTAT) begin
			regRdData <= {29'h00000000, irqStat};
		end else if (regAddr == `TBSO_OFS_IRQMASK) begin
			regRdData <= {29'h00000000, irqMask};
		end else begin
			regRdData <= 32'h00000000;
		end
	end
end

endmodule

// file: bench/tbso_trace_buffer_sync_asserts.sv
// Concurrent checks on the trace buffer sync block ports.
`timescale 1ns/1ps
module tbso_sync_asserts (
	input wire clk,
	input wire resetn,
	input wire contextSyncEvent,
	input wire debugEntry,
	input wire debugExit,
	input wire [1:0] currentEl,
	input wire traceBarrier,
	input wire dataBarrierReq,
	input wire dataBarrierDone,
	input wire traceValid,
	input wire traceReady,
	input wire traceProhibited,
	input wire memReq,
	input wire [31:0] memAddr,
	input wire memAccept,
	input wire memComplete,
	input wire pmuEvent
);
	logic synced, armed;
	logic [3:0] outst;
	////////////////////////////////////////////////////////////////
	// Port view of barrier arming; it cannot see internal copies, so it follows the note.
	always @(posedge clk) begin
		if (!resetn) begin
			synced <= 1'b0;
			armed <= 1'b0;
			outst <= 4'h0;
		end else begin
			synced <= contextSyncEvent || debugEntry || debugExit || (synced && traceProhibited);
			armed <= !dataBarrierDone && (armed || (traceBarrier && synced && traceProhibited));
			outst <= outst + {3'h0, memReq && memAccept} - {3'h0, memComplete};
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_retire;
		memReq && memAccept;
	endsequence
	a_mem_hold: assert property (memReq && !memAccept |=> memReq && $stable(memAddr))
		else $error("memory request dropped or changed");
	a_ready_refuse: assert property (memReq && !memAccept |-> !traceReady)
		else $error("ready while stage full");
	a_pmu_retire: assert property (s_retire |=> pmuEvent)
		else $error("no event after retire");
	a_done_pulse: assert property (dataBarrierDone |=> !dataBarrierDone)
		else $error("barrier done too long");
	a_armed_wait: assert property (dataBarrierDone && armed |-> outst == 4'h0 && !memReq)
		else $error("barrier done with writes open");
	a_fast_done: assert property (dataBarrierReq && !armed |=> dataBarrierDone)
		else $error("unarmed barrier late");
	a_top_prohibit: assert property (currentEl == 2'h3 |-> traceProhibited)
		else $error("trace allowed at top level");
	a_drop_prohib: assert property (traceValid && currentEl == 2'h3 && !memReq |=> !memReq)
		else $error("prohibited trace written");
endmodule
bind tbso_trace_buffer_sync tbso_sync_asserts chk (.*);

// file: bench/tbso_mem_model.sv
// Memory side of the trace buffer: accepts each write and completes it after a set delay.
`timescale 1ns/1ps
module tbso_mem_model (
	input wire clk,
	input wire memReq,
	input wire [31:0] memAddr,
	input wire [31:0] memData,
	input wire [7:0] doneWait,
	output logic memAccept,
	output logic memComplete,
	output logic [31:0] lastAddr,
	output logic [31:0] lastData,
	output int writes,
	output int dones
);
	int cyc;
	int due[$];
	initial begin
		memAccept = 1'b0;
		memComplete = 1'b0;
		cyc = 0;
		writes = 0;
		dones = 0;
	end
	// Accept a cycle after a request, then a gap; completions leave in order, one a cycle.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		memAccept <= memReq && !memAccept;
		memComplete <= due.size() > 0 && due[0] <= cyc;
		if (due.size() > 0 && due[0] <= cyc) begin
			void'(due.pop_front());
			dones <= dones + 1;
		end
		if (memReq && memAccept) begin
			due.push_back(cyc + doneWait);
			writes <= writes + 1;
			lastAddr <= memAddr;
			lastData <= memData;
		end
	end
endmodule

// file: bench/tbso_trace_buffer_sync_tb_top.sv
// Bench for the trace buffer sync block.
`timescale 1ns/1ps
`include "tbso_regs.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("Error %s exp %h got %h", n, e, g); end end
module tbso_trace_buffer_sync_tb_top;
	logic clk, resetn, regWr, regRd, inDebugState, traceUnitEnabled, traceValid, traceFlush;
	logic traceAfterCse, memAccept, memComplete, traceReady, traceProhibited, memReq;
	logic dataBarrierDone, sideValid, pmuEvent, irq;
	wire contextSyncEvent, debugEntry, debugExit, traceBarrier, dataBarrierReq;
	logic [1:0] currentEl;
	logic [4:0] pul;
	logic [7:0] regAddr, doneWait;
	logic [31:0] regWrData, regRdData, traceData, memAddr, memData, sideData;
	logic [31:0] lastAddr, lastData;
	int bad_count, checks_done, writes, dones, sides, cycles, w0, s0, i;
	assign {debugEntry, debugExit, contextSyncEvent, traceBarrier, dataBarrierReq} = pul;
	tbso_trace_buffer_sync uut (.*);
	tbso_mem_model mem (.*);
	////////////////////////////////////////////////////////////////
	// Clock, side word count and a cycle ceiling against a hung handshake.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		sides += sideValid;
		if (cycles == 4000) begin
			bad_count++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic pulse(input logic [4:0] m);
		pul <= m;
		@(posedge clk);
		pul <= 5'h00;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	// Read data appear in the cycle after the strobe and hold until the next read; they are taken at its closing edge.
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, e, input string n);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
		`CHK(n, e, regRdData & m)
	endtask
	task automatic send(input logic [31:0] d, input logic fl);
		traceData <= d;
		traceFlush <= fl;
		traceValid <= 1'b1;
		@(posedge clk);
		traceValid <= 1'b0;
		tick(6);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'b0;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWrData = 32'h00000000;
		pul = 5'h00;
		inDebugState = 1'b0;
		traceUnitEnabled = 1'b1;
		currentEl = 2'h1;
		traceValid = 1'b0;
		traceData = 32'h00000000;
		traceAfterCse = 1'b1;
		traceFlush = 1'b0;
		doneWait = 8'h01;
		tick(6);
		resetn <= 1'b1;
		tick(1);
		wr(8'h40, 32'hFFFFFFFF);
		rdc(`TBSO_OFS_CTRL, 32'hFFFFFFFF, 32'h00000000, "ctrl");
		rdc(8'h40, 32'hFFFFFFFF, 32'h00000000, "unmapped");
		$display("reset test done");
		for (int h = 0; h < 2; h++) begin
			wr(`TBSO_OFS_CTRL, {25'h0, h[0], 6'h01});
			pulse(5'h04);
			for (int e = 0; e < 4; e++) begin
				currentEl <= e[1:0];
				tick(1);
				`CHK("prohibited", e > h + 1, traceProhibited)
			end
		end
		w0 = writes;
		send(32'h0BAD0000, 1'b0);
		`CHK("dropped", w0, writes)
		currentEl <= `TBSO_EL2;
		wr(`TBSO_OFS_PTR_EL2, 32'h00000100);
		send(32'hA5A50001, 1'b0);
		`CHK("addr", 32'h00000100, lastAddr)
		`CHK("data", 32'hA5A50001, lastData)
		rdc(`TBSO_OFS_PTR_EL2, 32'hFFFFFFFF, 32'h00000104, "ptr2");
		wr(`TBSO_OFS_CTRL, 32'h00000001);
		currentEl <= `TBSO_EL1;
		send(32'hA5A50002, 1'b0);
		`CHK("addr", 32'h00000000, lastAddr)
		rdc(`TBSO_OFS_PTR_EL1, 32'hFFFFFFFF, 32'h00000004, "ptr1");
		$display("owner test done");
		wr(`TBSO_OFS_IRQMASK, 32'h00000005);
		pulse(5'h04);
		for (int p = 0; p < 4; p++) begin
			wr(`TBSO_OFS_CTRL, {28'h0, 1'b1, p[1:0], 1'b0});
			w0 = writes;
			s0 = sides;
			send(32'hC0DE0000 + p, p == 1);
			`CHK("mem", !p[0], writes != w0)
			`CHK("side", p[0] ^ p[1], sides != s0)
			if (p[0] ^ p[1]) `CHK("sidedata", 32'hC0DE0000 + p, sideData)
		end
		`CHK("irq", 1'b1, irq)
		rdc(`TBSO_OFS_STATUS, 32'hFC01003F, 32'h00010000, "status");
		rdc(`TBSO_OFS_IRQSTAT, 32'h00000007, 32'h00000005, "irqstat");
		`CHK("irq", 1'b0, irq)
		wr(`TBSO_OFS_CTRL, 32'h0000001E);
		send(32'hC0DE0004, 1'b0);
		rdc(`TBSO_OFS_STATUS, 32'hFC000000, 32'h7C000000, "class");
		wr(`TBSO_OFS_IRQMASK, 32'h00000000);
		tick(1);
		`CHK("masked", 1'b0, irq)
		$display("discard test done");
		wr(`TBSO_OFS_CTRL, 32'h00000001);
		pulse(5'h04);
		doneWait <= 8'h28;
		for (int s = 0; s < 3; s++) begin
			send(32'hBA550000 + s, 1'b0);
			currentEl <= (s == 2) ? `TBSO_EL1 : `TBSO_EL2;
			inDebugState <= s == 2;
			traceUnitEnabled <= s != 2;
			tick(1);
			// sync by event, halt exit or halt entry, trace held prohibited.
			// Sync, trace barrier and data barrier back to back, one assignment per edge.
			pul <= 5'h04 << s;
			@(posedge clk);
			pul <= 5'h02;
			@(posedge clk);
			pul <= 5'h01;
			@(posedge clk);
			pul <= 5'h00;
			i = 0;
			while (dataBarrierDone !== 1'b1 && i < 100) begin
				tick(1);
				i++;
			end
			`CHK("drained", 1'b1, dones == writes && i > 10)
			pulse(5'h04);
			currentEl <= `TBSO_EL1;
			inDebugState <= 1'b0;
			traceUnitEnabled <= 1'b1;
			tick(2);
		end
		send(32'hBA550003, 1'b0);
		pulse(5'h01);
		tick(1);
		`CHK("fast", 1'b1, dataBarrierDone && dones != writes)
		$display("barrier test done");
		test_done();
	end
endmodule
